// ==== dtcr_map.vh ====
`ifndef DTCR_MAP_VH
`define DTCR_MAP_VH

// ==================================================
// Register offsets (byte addresses)
`define DTCR_OFF_CTRL      8'h00
`define DTCR_OFF_AUX       8'h04
`define DTCR_OFF_CORE      8'h08
`define DTCR_OFF_CAPTURE_RELOAD_VALUE    8'h0C
`define DTCR_OFF_STATUS    8'h10

// ==================================================
// Control register fields
`define DTCR_AUX_RUN       0
`define DTCR_AUX_DOWN      1
`define DTCR_AUX_EXTCLK    2
`define DTCR_AUX_LATCLK    3
`define DTCR_CORE_RUN      4
`define DTCR_CORE_DOWN     5
`define DTCR_CORE_EXTDIR   6
`define DTCR_CORE_EXTCLK   7
`define DTCR_RELOAD_EN     8
`define DTCR_CLR_AFTER_CAP 9
`define DTCR_LATCH_OUT_EN  10
`define DTCR_CAP_SRC_LSB   11
`define DTCR_CAP_EDGE_LSB  13
`define DTCR_PRE_LSB       16
`define DTCR_CTRL_W        19

// Capture source codes
`define DTCR_SRC_PIN       2'h0
`define DTCR_SRC_CNT       2'h1
`define DTCR_SRC_DIR       2'h2
`define DTCR_SRC_BOTH      2'h3

// Edge select codes
`define DTCR_EDGE_RISE     2'h1
`define DTCR_EDGE_FALL     2'h2
`define DTCR_EDGE_BOTH     2'h3

// ==================================================
// Reset values and timing
`define DTCR_CTRL_RST      19'h00000
`define DTCR_MIN_DIV       4'h2
`define DTCR_TW            16
`define DTCR_RESP_OKAY     2'h0
`define DTCR_RESP_SLVERR   2'h2

`endif

// ==== dtcr_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Far side: count clocks, capture pin, companion signals
module dtcr_pins_model (
    // Clock
    input  wire logic i_mclk,
    // Pin levels
    output wire logic o_aux_count,
    output wire logic o_core_count,
    output wire logic o_capture_pin,
    output wire logic o_comp_count,
    output wire logic o_comp_dir,
    output var  logic o_core_dir
);
    logic [4:0] lv = 5'h00;
    assign o_aux_count   = lv[0];
    assign o_core_count  = lv[1];
    assign o_capture_pin = lv[2];
    assign o_comp_count  = lv[3];
    assign o_comp_dir    = lv[4];
    initial o_core_dir = 1'b0;
    // Levels held at least five clocks, well inside the mclk/2 edge limit
    task automatic flip(input int w);
        @(posedge i_mclk);
        lv[w] <= ~lv[w];
        repeat (4) @(posedge i_mclk);
    endtask
    task automatic pulse(input int w, input int n);
        repeat (2 * n) flip(w);
    endtask
    task automatic set_dir(input logic v);
        @(posedge i_mclk);
        o_core_dir <= v;
        repeat (4) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

// ==== dtcr_prescaler.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_map.vh"

// ==================================================
// Tick generator: base period of two clocks, scaled by 2^sel
module dtcr_prescaler (
    // Clock and reset
    input  wire       i_mclk,
    input  wire       i_reset_n,
    // Control
    input  wire [2:0] i_sel,
    // Tick
    output reg        o_tick
);
    reg [8:0] cnt_q;
    wire [8:0] last = ({5'h00, `DTCR_MIN_DIV} << i_sel) - 9'h001;

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cnt_q  <= 9'h000;
            o_tick <= 1'b0;
        end else if (cnt_q >= last) begin
            cnt_q  <= 9'h000;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 9'h001;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== dtcr_timer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_map.vh"

// Contract
// - Finest resolution is two system clocks
// - Auxiliary timer, core timer, shared capture register
// - Clock from prescaler or external input
// - Direction by software or external level
// - Auxiliary direction is software only
// - Core overflow or underflow flips latch
// - Latch clocks auxiliary timer, drives pin
// - Core wrap pulse clocks compare timers
// - Core wrap may reload from capture register
// - Capture pin edge copies auxiliary timer
// - Optional clear of auxiliary after capture
// - Capture from companion count/direction edges

module dtcr_timer (
    // Clock and reset
    input  wire        i_mclk,
    input  wire        i_reset_n,
    // AXI4-Lite write address
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    // AXI4-Lite write data
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    // AXI4-Lite write response
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    // AXI4-Lite read address
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    // AXI4-Lite read data
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // External pins and sibling signals
    input  wire        i_aux_count_input,
    input  wire        i_core_count_input,
    input  wire        i_core_direction_input,
    input  wire        i_capture_input_pin,
    input  wire        i_companion_count_input,
    input  wire        i_companion_direction_input,
    // Outputs
    output reg         o_toggle_latch_pin,
    output reg         o_core_wrap_pulse
);

    // ==================================================
    // Register state
    reg [`DTCR_CTRL_W-1:0] ctrl_q;
    reg [`DTCR_TW-1:0]     aux_q;
    reg [`DTCR_TW-1:0]     core_q;
    reg [`DTCR_TW-1:0]     capture_reload_value_q;
    reg                    latch_q;
    reg                    cap_flag_q;
    reg                    wrap_flag_q;

    wire tick;
    dtcr_prescaler u_pre (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_sel     (ctrl_q[`DTCR_PRE_LSB +: 3]),
        .o_tick    (tick)
    );

    // ==================================================
    // Synchronisers and edge detection
    // Stage 1 is read only by stage 2; edges use stages 2 and 3.
    reg [5:0] s1_q;
    reg [5:0] s2_q;
    reg [5:0] s3_q;
    wire [5:0] raw = {i_companion_direction_input, i_companion_count_input,
                      i_capture_input_pin, i_core_direction_input,
                      i_core_count_input, i_aux_count_input};

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    wire [5:0] rise = s2_q & ~s3_q;
    wire [5:0] fall = ~s2_q & s3_q;

    function edge_hit;
        input [1:0] sel;
        input       r;
        input       f;
        begin
            edge_hit = ((sel == `DTCR_EDGE_RISE) & r) |
                       ((sel == `DTCR_EDGE_FALL) & f) |
                       ((sel == `DTCR_EDGE_BOTH) & (r | f));
        end
    endfunction

    // ==================================================
    // Clock source selection
    wire [1:0] edge_sel = ctrl_q[`DTCR_CAP_EDGE_LSB +: 2];
    wire [1:0] cap_src  = ctrl_q[`DTCR_CAP_SRC_LSB +: 2];

    // Core counts on prescaler tick or a rising external edge
    wire core_en = ctrl_q[`DTCR_CORE_RUN] &
                   (ctrl_q[`DTCR_CORE_EXTCLK] ? rise[1] : tick);
    // Direction: external level overrides the software bit
    wire core_dn = ctrl_q[`DTCR_CORE_EXTDIR] ? s2_q[2]
                                             : ctrl_q[`DTCR_CORE_DOWN];
    wire core_wrap = core_en & (core_dn ? (core_q == {`DTCR_TW{1'b0}})
                                        : (core_q == {`DTCR_TW{1'b1}}));

    // Auxiliary direction has no external input at all
    wire aux_dn = ctrl_q[`DTCR_AUX_DOWN];
    wire aux_clk = ctrl_q[`DTCR_AUX_LATCLK] ? core_wrap :
                   (ctrl_q[`DTCR_AUX_EXTCLK] ? rise[0] : tick);
    wire aux_en = ctrl_q[`DTCR_AUX_RUN] & aux_clk;

    // Capture trigger selection
    reg cap_hit;
    always @* begin
        case (cap_src)
            `DTCR_SRC_PIN:  cap_hit = edge_hit(edge_sel, rise[3], fall[3]);
            `DTCR_SRC_CNT:  cap_hit = edge_hit(edge_sel, rise[4], fall[4]);
            `DTCR_SRC_DIR:  cap_hit = edge_hit(edge_sel, rise[5], fall[5]);
            default:        cap_hit = edge_hit(edge_sel, rise[4], fall[4]) |
                                      edge_hit(edge_sel, rise[5], fall[5]);
        endcase
    end

    // ==================================================
    // AXI4-Lite slave
    reg        aw_got_q;
    reg        w_got_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;

    wire aw_ok = aw_got_q | (i_awvalid & o_awready);
    wire w_ok  = w_got_q  | (i_wvalid & o_wready);
    wire [7:0]  wa = aw_got_q ? awaddr_q : i_awaddr;
    wire [31:0] wd = w_got_q  ? wdata_q  : i_wdata;
    wire [3:0]  ws = w_got_q  ? wstrb_q  : i_wstrb;
    wire do_wr = aw_ok & w_ok & ~o_bvalid;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge[8*k +: 8] = st[k] ? nw[8*k +: 8] : old[8*k +: 8];
        end
    endfunction

    wire wr_ctrl   = do_wr & (wa == `DTCR_OFF_CTRL);
    wire wr_aux    = do_wr & (wa == `DTCR_OFF_AUX);
    wire wr_core   = do_wr & (wa == `DTCR_OFF_CORE);
    wire wr_capture_reload_value = do_wr & (wa == `DTCR_OFF_CAPTURE_RELOAD_VALUE);
    wire wr_status = do_wr & (wa == `DTCR_OFF_STATUS);
    wire wr_map    = wr_ctrl | wr_aux | wr_core | wr_capture_reload_value | wr_status;
    wire [31:0] m_ctrl = merge({13'h0000, ctrl_q}, wd, ws);
    wire [31:0] m_aux  = merge({16'h0000, aux_q}, wd, ws);
    wire [31:0] m_core = merge({16'h0000, core_q}, wd, ws);
    wire [31:0] m_cap  = merge({16'h0000, capture_reload_value_q}, wd, ws);

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `DTCR_RESP_OKAY;
        end else begin
            if (i_awvalid & o_awready) begin
                awaddr_q  <= i_awaddr;
                o_awready <= 1'b0;
                aw_got_q  <= 1'b1;
            end
            if (i_wvalid & o_wready) begin
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                o_wready <= 1'b0;
                w_got_q  <= 1'b1;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= wr_map ? `DTCR_RESP_OKAY : `DTCR_RESP_SLVERR;
            end
            if (o_bvalid & i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one cycle to answer, address held off until taken
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `DTCR_RESP_OKAY;
        end else if (i_arvalid & o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= `DTCR_RESP_OKAY;
            case (i_araddr)
                `DTCR_OFF_CTRL:   o_rdata <= {13'h0000, ctrl_q};
                `DTCR_OFF_AUX:    o_rdata <= {16'h0000, aux_q};
                `DTCR_OFF_CORE:   o_rdata <= {16'h0000, core_q};
                `DTCR_OFF_CAPTURE_RELOAD_VALUE: o_rdata <= {16'h0000, capture_reload_value_q};
                `DTCR_OFF_STATUS: o_rdata <= {29'h00000000, latch_q,
                                              wrap_flag_q, cap_flag_q};
                default: begin
                    o_rdata <= 32'h00000000;
                    o_rresp <= `DTCR_RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid & i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ==================================================
    // Timers, capture and reload
    wire aux_clr = cap_hit & ctrl_q[`DTCR_CLR_AFTER_CAP];

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_q   <= `DTCR_CTRL_RST;
            aux_q    <= {`DTCR_TW{1'b0}};
            core_q   <= {`DTCR_TW{1'b0}};
            capture_reload_value_q <= {`DTCR_TW{1'b0}};
            latch_q  <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_q <= m_ctrl[`DTCR_CTRL_W-1:0];

            // Hardware capture outranks a software write in the same cycle
            if (cap_hit)
                capture_reload_value_q <= aux_q;
            else if (wr_capture_reload_value)
                capture_reload_value_q <= m_cap[15:0];

            // Capture sees the old value, then the counter restarts at zero
            if (aux_clr)
                aux_q <= {`DTCR_TW{1'b0}};
            else if (aux_en)
                aux_q <= aux_dn ? aux_q - 16'h0001 : aux_q + 16'h0001;
            else if (wr_aux)
                aux_q <= m_aux[15:0];

            if (core_wrap & ctrl_q[`DTCR_RELOAD_EN])
                core_q <= capture_reload_value_q;
            else if (core_en)
                core_q <= core_dn ? core_q - 16'h0001 : core_q + 16'h0001;
            else if (wr_core)
                core_q <= m_core[15:0];

            if (core_wrap)
                latch_q <= ~latch_q;
        end
    end

    // Sticky status, set wins over a software clear
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cap_flag_q  <= 1'b0;
            wrap_flag_q <= 1'b0;
        end else begin
            cap_flag_q  <= cap_hit   | (cap_flag_q  & ~(wr_status & ws[0] & wd[0]));
            wrap_flag_q <= core_wrap | (wrap_flag_q & ~(wr_status & ws[0] & wd[1]));
        end
    end

    // ==================================================
    // Outputs, registered
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_toggle_latch_pin <= 1'b0;
            o_core_wrap_pulse  <= 1'b0;
        end else begin
            o_toggle_latch_pin <= ctrl_q[`DTCR_LATCH_OUT_EN] & latch_q;
            o_core_wrap_pulse  <= core_wrap;
        end
    end

endmodule
`default_nettype wire

// ==== dtcr_timer_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Port checks for the timer block
module dtcr_chk (
    // Clock and reset
    input wire logic        i_mclk,
    input wire logic        i_reset_n,
    // Register bus
    input wire logic [7:0]  i_awaddr,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic [7:0]  i_araddr,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    // Timer output
    input wire logic        o_core_wrap_pulse
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_reset_idle:
    assert property ($rose(i_reset_n) |-> o_awready && o_wready && o_arready && !o_bvalid
        && !o_rvalid) else $error("bus not idle after reset");
    a_write_answer:
    assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid && !o_awready
        && !o_wready) else $error("write answer late");
    a_b_stands:
    assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_b_ends:
    assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
        else $error("write response not closed");
    a_read_answer:
    assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read answer late");
    a_r_stands:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read data dropped");
    a_bad_write:
    assert property (i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr > 8'h10
        |=> o_bresp == 2'h2) else $error("unmapped write not refused");
    a_bad_read:
    assert property (i_arvalid && o_arready && i_araddr > 8'h10 |=> o_rresp == 2'h2
        && o_rdata == 32'h0) else $error("unmapped read not refused");
    a_wrap_single:
    assert property (o_core_wrap_pulse |=> !o_core_wrap_pulse) else $error("wrap pulse too long");
endmodule

bind dtcr_timer dtcr_chk u_chk (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_core_wrap_pulse(o_core_wrap_pulse)
);
`default_nettype wire

// ==== test_dual_timer_capture_reload.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Self-checking bench for the dual timer block
module test_dual_timer_capture_reload;
    logic        i_mclk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0]  i_wstrb;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire  [1:0]  o_bresp, o_rresp;
    wire  [31:0] o_rdata;
    wire         aux_cnt, core_cnt, core_dir, cap_pin, comp_cnt, comp_dir, latch_pin, wrap;
    int          num_errors = 0;
    int          tests_run = 0;

    dtcr_timer uut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .i_aux_count_input(aux_cnt), .i_core_count_input(core_cnt),
        .i_core_direction_input(core_dir), .i_capture_input_pin(cap_pin),
        .i_companion_count_input(comp_cnt), .i_companion_direction_input(comp_dir),
        .o_toggle_latch_pin(latch_pin), .o_core_wrap_pulse(wrap));
    dtcr_pins_model u_pins (
        .i_mclk(i_mclk), .o_aux_count(aux_cnt), .o_core_count(core_cnt),
        .o_capture_pin(cap_pin), .o_comp_count(comp_cnt), .o_comp_dir(comp_dir),
        .o_core_dir(core_dir));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic end_of_test;
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    task automatic limit(input int n);
        if (n >= 200) begin
            chk("wait bound", 32'h0, 32'h1);
            end_of_test();
        end
    endtask
    // ==================================================
    // Bus cycles: each channel held until its own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid && n < 200);
        i_bready <= 1'b0;
        limit(n);
        chk("bresp", {30'h0, o_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid && n < 200);
        i_rready <= 1'b0;
        d = o_rdata;
        limit(n);
        chk("rresp", {30'h0, o_rresp}, {30'h0, er});
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d, 2'h0);
        chk("register", d, e);
    endtask
    // ==================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] d;
        for (int k = 0; k <= 16; k += 4) rc(8'(k), 32'h0);
        wr(8'h00, 32'hFFF80600, 2'h0);
        rc(8'h00, 32'h00000600);
        wr(8'h0C, 32'h0000ABCD, 2'h0);
        rc(8'h0C, 32'h0000ABCD);
        // Only the low byte lane may land
        i_wstrb <= 4'h1;
        wr(8'h0C, 32'h00001234, 2'h0);
        i_wstrb <= 4'hF;
        rc(8'h0C, 32'h0000AB34);
        wr(8'h14, 32'hFFFFFFFF, 2'h2);
        rd(8'h14, d, 2'h2);
        chk("unmapped data", d, 32'h0);
        wr(8'h00, 32'h0, 2'h0);
    endtask
    task automatic t_prescale;
        logic [31:0] d;
        int e;
        for (int s = 0; s < 4; s++) begin
            wr(8'h04, 32'h0, 2'h0);
            wr(8'h00, 32'h1 | (s << 16), 2'h0);
            repeat (40) @(posedge i_mclk);
            wr(8'h00, 32'h0, 2'h0);
            rd(8'h04, d, 2'h0);
            e = 43 / (2 << s);
            chk("aux ticks", 32'(d >= e - 1 && d <= e + 1), 32'h1);
        end
        wr(8'h04, 32'h00000100, 2'h0);
        wr(8'h00, 32'h00000003, 2'h0);
        repeat (40) @(posedge i_mclk);
        wr(8'h00, 32'h0, 2'h0);
        rd(8'h04, d, 2'h0);
        chk("aux down", 32'(d >= 32'hEA && d <= 32'hEC), 32'h1);
    endtask
    task automatic t_extclk;
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h08, 32'h00000010, 2'h0);
        wr(8'h00, 32'h000000D5, 2'h0);
        u_pins.set_dir(1'b1);
        u_pins.pulse(1, 5);
        u_pins.set_dir(1'b0);
        u_pins.pulse(1, 3);
        u_pins.pulse(0, 4);
        repeat (8) @(posedge i_mclk);
        wr(8'h00, 32'h0, 2'h0);
        rc(8'h08, 32'h0000000E);
        rc(8'h04, 32'h00000004);
    endtask
    task automatic t_wrap;
        logic [31:0] d;
        int n = 0;
        int p = 0;
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h0C, 32'h0000FFFA, 2'h0);
        wr(8'h08, 32'h0000FFFC, 2'h0);
        wr(8'h00, 32'h00000519, 2'h0);
        // A missed reload would push the second wrap far past the bound
        while (p < 2 && n < 200) begin
            @(posedge i_mclk);
            n++;
            if (wrap) begin
                p++;
                repeat (2) @(posedge i_mclk);
                chk("latch pin", {31'h0, latch_pin}, 32'(p % 2));
            end
        end
        limit(n);
        chk("wraps", 32'(p), 32'h2);
        wr(8'h00, 32'h0, 2'h0);
        rc(8'h04, 32'h00000002);
        // Wrap flag set, latch back at zero after two flips; then cleared
        rc(8'h10, 32'h00000002);
        wr(8'h10, 32'h00000003, 2'h0);
        rc(8'h10, 32'h00000000);
        rd(8'h08, d, 2'h0);
        chk("reloaded core", 32'(d >= 32'hFFFA && d <= 32'hFFFE), 32'h1);
    endtask
    task automatic t_capture;
        logic [7:0]  cs [11] = '{8'h51, 8'h41, 8'h42, 8'h52, 8'h77, 8'h77, 8'h99, 8'h9E,
                                 8'h6E, 8'h63, 8'h40};
        logic [15:0] cap = 16'h0;
        logic [15:0] v;
        wr(8'h0C, 32'h0, 2'h0);
        for (int k = 0; k < 11; k++) begin
            v = 16'h0A00 + 16'(k);
            wr(8'h04, {16'h0, v}, 2'h0);
            wr(8'h00, {17'h0, cs[k][1:0], cs[k][3:2], 1'b0, k != 4, 9'h0}, 2'h0);
            u_pins.flip(cs[k][7:5]);
            if (cs[k][4]) cap = v;
            rc(8'h0C, {16'h0, cap});
            rc(8'h04, {16'h0, (cs[k][4] && k != 4) ? 16'h0 : v});
        end
    endtask
    initial begin
        i_reset_n = 1'b0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        i_awaddr = 8'h00;
        i_araddr = 8'h00;
        i_wdata = 32'h0;
        i_wstrb = 4'hF;
        repeat (5) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        t_regs();
        t_prescale();
        t_extclk();
        t_wrap();
        t_capture();
        end_of_test();
    end
endmodule
`default_nettype wire
